// ===== pkg/was_pkg.sv
/*
   shared constants for the waveform amplitude scaler: sample and scale
   widths, interpolation ratio, full-scale percentage and fifo depth.
   assumes a single 40 mhz baseband-side clock, a one-clock-per-sample
   interpolator phase rate and a synchronous sample memory port.
*/
// Functional notes
// [RQ1] interpolate four points per incoming baseband sample
// [RQ2] flag over-range when interpolated sample exceeds limit
// [RQ3] runtime scale outgoing samples, memory left untouched
// [RQ4] runtime scale always applied to stored amplitude
// [RQ5] scale writable running or stopped, any segment
// [RQ6] new runtime scale takes effect without commit
// [RQ7] permanent target is percent of full scale
// [RQ8] find peak, form ratio, multiply every sample
// [RQ9] permanent scaling overwrites baseband_generator_memory samples
// [RQ10] permanent products round down, loss is permanent
// [RQ11] runtime scale loadable from header or settings
// [RQ12] runtime scaling applied before the interpolator
package was_pkg;
   // sample and scale formats
   localparam int          WAS_SAMPLE_W   = 16;
   localparam int          WAS_SCALE_W    = 16;  // unsigned q1.15, 1.0 = 8000
   localparam int          WAS_SCALE_FRAC = 15;
   localparam logic [15:0] WAS_SCALE_ONE  = 16'h8000;
   localparam int          WAS_ADDR_W     = 12;
   // interpolation
   localparam int          WAS_INTERP     = 4;
   localparam int          WAS_PH_W       = 2;
   // permanent scaling target, percent of full scale
   localparam logic [7:0]  WAS_FULL_PCT   = 8'h64;   // 100 percent
   localparam int          WAS_PCT_W      = 8;
   // buffering
   localparam int          WAS_FIFO_DEPTH = 16;
   // full-scale magnitude of a signed sample
   localparam logic [15:0] WAS_FULL_MAG   = 16'h7fff;
   typedef enum logic [2:0] {
      WAS_IDLE,
      WAS_PEAK_RD,
      WAS_RATIO,
      WAS_SCL_RD,
      WAS_SCL_WR,
      WAS_DONE
   } was_perm_t;
endpackage

// ===== design/was_fifo.sv
/*
   synchronous valid/ready fifo of parameterised width and depth.
   assumes both sides on one clock; depth is a power of two.
*/
`timescale 1ns/1ps
module was_fifo
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
)
(
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output      logic             in_ready,
   output      logic [WIDTH-1:0] out_data,
   output      logic             out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   // flags straight from the occupancy count; full at exactly DEPTH
   assign in_ready  = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign out_data  = mem_r[rd_ptr_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // ------------------------------------------------------------
   // storage and pointers
   // ------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (push)
         mem_r[wr_ptr_r] <= in_data;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_r <= wr_ptr_r + AW'(1);
         if (pop)
            rd_ptr_r <= rd_ptr_r + AW'(1);
         if (push && !pop)
            count_r <= count_r + (AW+1)'(1);
         else if (pop && !push)
            count_r <= count_r - (AW+1)'(1);
      end
   end
endmodule

// ===== design/was_scaler.sv
/*
   waveform amplitude scaler: runtime scaling of played i/q samples ahead
   of a four-phase linear interpolator with over-range detection, plus an
   offline permanent rescale of a segment in sample memory.
   assumes the memory answers a read one clock after the address, and the
   converter takes one interpolated i/q pair per clock when ready.
*/
`timescale 1ns/1ps
module was_scaler
   import was_pkg::*;
#(
   parameter int FIFO_DEPTH = WAS_FIFO_DEPTH
)
(
   input  wire logic                    clock,
   input  wire logic                    rst_n,
   // playback samples straight from memory
   input  wire logic [WAS_SAMPLE_W-1:0] play_i,
   input  wire logic [WAS_SAMPLE_W-1:0] play_q,
   input  wire logic                    play_valid,
   output      logic                    play_ready,
   // runtime scale: settings value or header value
   input  wire logic [WAS_SCALE_W-1:0]  rt_scale_setting,
   input  wire logic [WAS_SCALE_W-1:0]  rt_scale_header,
   input  wire logic                    rt_scale_header_valid,
   // converter side
   output      logic [WAS_SAMPLE_W-1:0] dac_i,
   output      logic [WAS_SAMPLE_W-1:0] dac_q,
   output      logic                    dac_valid,
   input  wire logic                    dac_ready,
   output      logic                    over_range,
   // permanent scaling control
   input  wire logic                    perm_start,
   input  wire logic [WAS_PCT_W-1:0]    perm_target_pct,
   input  wire logic [WAS_ADDR_W-1:0]   seg_base,
   input  wire logic [WAS_ADDR_W-1:0]   seg_len,
   output      logic                    perm_busy,
   output      logic                    perm_done,
   // baseband_generator_memory port
   output      logic [WAS_ADDR_W-1:0]   mem_addr,
   output      logic                    mem_rd,
   output      logic                    mem_wr,
   output      logic [WAS_SAMPLE_W-1:0] mem_wdata_i,
   output      logic [WAS_SAMPLE_W-1:0] mem_wdata_q,
   input  wire logic [WAS_SAMPLE_W-1:0] mem_rdata_i,
   input  wire logic [WAS_SAMPLE_W-1:0] mem_rdata_q
);
   localparam int SW = WAS_SAMPLE_W;
   localparam int PW = SW + WAS_SCALE_W;
   // one guard bit: a scale above 1.0 must reach the range check intact
   localparam int XW = SW + 1;

   // ------------------------------------------------------------
   // runtime scaling ahead of the fifo
   // ------------------------------------------------------------
   logic [WAS_SCALE_W-1:0] rt_scale;
   logic signed [PW:0]     prod_i;
   logic signed [PW:0]     prod_q;
   logic [2*XW-1:0]        fifo_in;
   logic [2*XW-1:0]        fifo_out;
   logic                   fifo_valid;
   logic                   fifo_ready;
   logic                   fifo_in_ready;
   logic                   perm_busy_r;

   // live value used every sample, so a write lands without commit
   assign rt_scale = rt_scale_header_valid ? rt_scale_header     // [RQ11]
                                           : rt_scale_setting;  // [RQ6] [RQ5]
   // product always from the stored sample, never a rescaled one
   assign prod_i = $signed(play_i) * $signed({1'b0, rt_scale}); // [RQ3] [RQ4]
   assign prod_q = $signed(play_q) * $signed({1'b0, rt_scale}); // [RQ4]
   assign fifo_in = {prod_i[WAS_SCALE_FRAC +: XW],
                     prod_q[WAS_SCALE_FRAC +: XW]};             // [RQ12]
   // playback pauses while a permanent rescale owns the memory
   assign play_ready = fifo_in_ready && !perm_busy_r;

   was_fifo
   #(
      .WIDTH (2*XW),
      .DEPTH (FIFO_DEPTH)
   )
   u_fifo
   (
      .clock     (clock),
      .rst_n     (rst_n),
      .in_data   (fifo_in),
      .in_valid  (play_valid && !perm_busy_r),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out),
      .out_valid (fifo_valid),
      .out_ready (fifo_ready)
   );

   // ------------------------------------------------------------
   // four-phase interpolator
   // ------------------------------------------------------------
   logic signed [XW-1:0]   prev_i_r;
   logic signed [XW-1:0]   prev_q_r;
   logic signed [XW-1:0]   cur_i_r;
   logic signed [XW-1:0]   cur_q_r;
   logic [WAS_PH_W-1:0]    phase_r;
   logic                   primed_r;
   logic signed [XW+2:0]   interp_i;
   logic signed [XW+2:0]   interp_q;
   logic                   step;

   // a new sample is taken when the last phase has been sent
   assign step = !primed_r || (dac_ready && phase_r == WAS_PH_W'(WAS_INTERP-1));
   assign fifo_ready = step;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prev_i_r <= '0;
         prev_q_r <= '0;
         cur_i_r  <= '0;
         cur_q_r  <= '0;
         phase_r  <= '0;
         primed_r <= 1'b0;
      end
      else if (step)
      begin
         if (fifo_valid)
         begin
            prev_i_r <= cur_i_r;
            prev_q_r <= cur_q_r;
            cur_i_r  <= fifo_out[2*XW-1:XW];
            cur_q_r  <= fifo_out[XW-1:0];
            phase_r  <= '0;
            primed_r <= 1'b1;
         end
         else
            primed_r <= 1'b0;  // underrun: hold until data returns
      end
      else if (dac_ready)
         phase_r <= phase_r + WAS_PH_W'(1);  // [RQ1]
   end

   // prev + (cur-prev)*phase/4 on the guarded width; linear, so the only
   // excursions past full scale come from a runtime gain above 1.0 or an 8000 sample at 1.0
   function automatic logic signed [XW+2:0] lerp
   (
      input logic signed [XW-1:0] a,
      input logic signed [XW-1:0] b,
      input logic [WAS_PH_W-1:0]  ph
   );
      logic signed [XW+2:0] d;
      d    = (XW+3)'(b) - (XW+3)'(a);
      lerp = (XW+3)'(a) + (XW+3)'((d * $signed({1'b0, ph})) >>> 2); // [RQ1]
   endfunction

   assign interp_i = lerp(prev_i_r, cur_i_r, phase_r);
   assign interp_q = lerp(prev_q_r, cur_q_r, phase_r);

   // registered converter outputs; over-range flags any excursion past
   // the signed limit, which a scaled-down stream avoids
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dac_i      <= '0;
         dac_q      <= '0;
         dac_valid  <= 1'b0;
         over_range <= 1'b0;
      end
      else
      begin
         dac_valid  <= primed_r && dac_ready;
         dac_i      <= interp_i[SW-1:0];
         dac_q      <= interp_q[SW-1:0];
         over_range <= primed_r && dac_ready &&
            (interp_i > (XW+3)'($signed({1'b0, WAS_FULL_MAG})) ||
             interp_q > (XW+3)'($signed({1'b0, WAS_FULL_MAG})) ||
             interp_i < -(XW+3)'($signed({1'b0, WAS_FULL_MAG})) ||
             interp_q < -(XW+3)'($signed({1'b0, WAS_FULL_MAG}))); // [RQ2]
      end
   end

   // ------------------------------------------------------------
   // permanent rescale of a stored segment
   // ------------------------------------------------------------
   was_perm_t              st_r;
   logic [WAS_ADDR_W-1:0]  idx_r;
   logic [SW-1:0]          peak_r;
   logic [WAS_SCALE_W+7:0] ratio_r;
   logic [SW-1:0]          mag_i;
   logic [SW-1:0]          mag_q;
   logic signed [SW+WAS_SCALE_W+8:0] sc_i;
   logic signed [SW+WAS_SCALE_W+8:0] sc_q;

   assign mag_i = mem_rdata_i[SW-1] ? SW'(-mem_rdata_i) : mem_rdata_i;
   assign mag_q = mem_rdata_q[SW-1] ? SW'(-mem_rdata_q) : mem_rdata_q;
   // arithmetic shift floors the product: fractions are rounded down
   assign sc_i = ($signed(mem_rdata_i) * $signed({1'b0, ratio_r}))
                 >>> WAS_SCALE_FRAC;                             // [RQ10]
   assign sc_q = ($signed(mem_rdata_q) * $signed({1'b0, ratio_r}))
                 >>> WAS_SCALE_FRAC;                             // [RQ10]
   assign perm_busy = perm_busy_r;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r        <= WAS_IDLE;
         idx_r       <= '0;
         peak_r      <= '0;
         ratio_r     <= '0;
         perm_busy_r <= 1'b0;
         perm_done   <= 1'b0;
         mem_addr    <= '0;
         mem_rd      <= 1'b0;
         mem_wr      <= 1'b0;
         mem_wdata_i <= '0;
         mem_wdata_q <= '0;
      end
      else
      begin
         mem_rd    <= 1'b0;
         mem_wr    <= 1'b0;
         perm_done <= 1'b0;
         case (st_r)
            WAS_IDLE:
               if (perm_start && seg_len != '0)
               begin
                  perm_busy_r <= 1'b1;
                  peak_r      <= '0;
                  idx_r       <= '0;
                  mem_addr    <= seg_base;
                  mem_rd      <= 1'b1;
                  st_r        <= WAS_PEAK_RD;
               end
            WAS_PEAK_RD:
            begin
               // read data of the previous address arrives now
               if (!mem_rd)
               begin
                  if (mag_i > peak_r || mag_q > peak_r)
                     peak_r <= (mag_i > mag_q) ? mag_i : mag_q;  // [RQ8]
                  if (idx_r == seg_len - WAS_ADDR_W'(1))
                     st_r <= WAS_RATIO;
                  else
                  begin
                     idx_r    <= idx_r + WAS_ADDR_W'(1);
                     mem_addr <= seg_base + idx_r + WAS_ADDR_W'(1);
                     mem_rd   <= 1'b1;
                  end
               end
            end
            WAS_RATIO:
            begin
               // ratio = target% / peak%; peak% = peak/fullscale*100
               if (peak_r == '0)
                  ratio_r <= {8'h00, WAS_SCALE_ONE};
               else
                  ratio_r <= (WAS_SCALE_W+8)'(
                     ({32'h0, perm_target_pct} * {32'h0, WAS_FULL_MAG}
                      << WAS_SCALE_FRAC) /
                     ({32'h0, WAS_FULL_PCT} * {40'h0, peak_r})); // [RQ7] [RQ8]
               idx_r    <= '0;
               mem_addr <= seg_base;
               mem_rd   <= 1'b1;
               st_r     <= WAS_SCL_RD;
            end
            WAS_SCL_RD:
               if (!mem_rd)
               begin
                  mem_wdata_i <= sc_i[SW-1:0];  // [RQ8]
                  mem_wdata_q <= sc_q[SW-1:0];
                  mem_wr      <= 1'b1;          // [RQ9]
                  st_r        <= WAS_SCL_WR;
               end
            WAS_SCL_WR:
               if (idx_r == seg_len - WAS_ADDR_W'(1))
                  st_r <= WAS_DONE;
               else
               begin
                  idx_r    <= idx_r + WAS_ADDR_W'(1);
                  mem_addr <= seg_base + idx_r + WAS_ADDR_W'(1);
                  mem_rd   <= 1'b1;
                  st_r     <= WAS_SCL_RD;
               end
            WAS_DONE:
            begin
               perm_busy_r <= 1'b0;
               perm_done   <= 1'b1;
               st_r        <= WAS_IDLE;
            end
            default:
               st_r <= WAS_IDLE;
         endcase
      end
   end
endmodule

// ===== testbench/was_mem_model.sv
/*
   sample memory model: 16 i/q words, read data one clock after mem_rd.
   assumes the scaler keeps addresses within the low sixteen words.
*/
`timescale 1ns/1ps
module was_mem_model
(
   input  wire logic        clock,
   input  wire logic [11:0] mem_addr,
   input  wire logic        mem_rd,
   input  wire logic        mem_wr,
   input  wire logic [15:0] mem_wdata_i,
   input  wire logic [15:0] mem_wdata_q,
   output      logic [15:0] mem_rdata_i,
   output      logic [15:0] mem_rdata_q
);
   logic [15:0] mi [16];
   logic [15:0] mq [16];
   initial mem_rdata_i = 16'h0000;
   initial mem_rdata_q = 16'h0000;
   // read data lasts one cycle, then toggles so stale use shows up
   always @(posedge clock)
   begin
      if (mem_rd)
      begin
         mem_rdata_i <= mi[mem_addr[3:0]];
         mem_rdata_q <= mq[mem_addr[3:0]];
      end
      else
      begin
         mem_rdata_i <= ~mem_rdata_i;
         mem_rdata_q <= ~mem_rdata_q;
      end
      if (mem_wr)
      begin
         mi[mem_addr[3:0]] <= mem_wdata_i;
         mq[mem_addr[3:0]] <= mem_wdata_q;
      end
   end
endmodule

// ===== testbench/was_scaler_props.sv
/*
   port checker for the scaler, bound to was_scaler.
   assumes one clock domain and the async low reset.
*/
`timescale 1ns/1ps
module was_scaler_props
   import was_pkg::*;
#(
   parameter int FIFO_DEPTH = WAS_FIFO_DEPTH
)
(
   input wire logic                  clock,
   input wire logic                  rst_n,
   input wire logic                  play_ready,
   input wire logic                  dac_valid,
   input wire logic                  over_range,
   input wire logic                  perm_start,
   input wire logic [WAS_ADDR_W-1:0] seg_base,
   input wire logic [WAS_ADDR_W-1:0] seg_len,
   input wire logic                  perm_busy,
   input wire logic                  perm_done,
   input wire logic [WAS_ADDR_W-1:0] mem_addr,
   input wire logic                  mem_rd,
   input wire logic                  mem_wr
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // a start counts only from idle with a non-empty segment
   sequence s_go;
      perm_start && !perm_busy && !perm_done && seg_len != 12'h000;
   endsequence
   sequence s_first_rd;
      mem_rd && mem_addr == seg_base;
   endsequence
   start_busy_a : assert property (s_go |=> perm_busy)
      else $error("rescale start did not raise busy");
   start_rd_a : assert property (s_go |-> ##[1:2] s_first_rd)
      else $error("rescale did not read the segment base");
   busy_play_a : assert property (perm_busy |-> !play_ready)
      else $error("playback accepted during rescale");
   idle_mem_a : assert property (!perm_busy |-> !mem_rd && !mem_wr)
      else $error("memory touched outside a rescale");
   wr_in_seg_a : assert property (mem_wr |-> mem_addr >= seg_base
      && mem_addr < seg_base + seg_len)
      else $error("write outside the segment");
   // the next read may follow a write at once, but a write never repeats
   wr_single_a : assert property (mem_wr |=> !mem_wr)
      else $error("write held longer than one cycle");
   done_pulse_a : assert property (perm_done |=> !perm_done)
      else $error("done longer than one cycle");
   busy_end_a : assert property ($fell(perm_busy)
      |-> perm_done || $past(perm_done))
      else $error("busy fell without done");
   over_point_a : assert property (over_range |-> dac_valid)
      else $error("over range without an output point");
endmodule

bind was_scaler was_scaler_props #(.FIFO_DEPTH(FIFO_DEPTH)) i_props
(
   .clock(clock), .rst_n(rst_n), .play_ready(play_ready),
   .dac_valid(dac_valid), .over_range(over_range),
   .perm_start(perm_start), .seg_base(seg_base), .seg_len(seg_len),
   .perm_busy(perm_busy), .perm_done(perm_done), .mem_addr(mem_addr),
   .mem_rd(mem_rd), .mem_wr(mem_wr)
);

// ===== testbench/tb.sv
/*
   testbench for was_scaler: playback scaling, fifo fill, rescale.
   assumes the memory model answers one clock after mem_rd.
*/
`timescale 1ns/1ps
module tb;
   logic        clock, rst_n, play_valid, hdr_v, dac_ready, perm_start;
   logic [15:0] play_i, play_q, scl_set, scl_hdr, dac_i, dac_q;
   logic [15:0] wd_i, wd_q, rd_i, rd_q, last_i, last_q;
   logic [11:0] seg_base, seg_len, mem_addr;
   logic [7:0]  pct;
   logic        play_ready, dac_valid, over_range, perm_busy, perm_done;
   logic        mem_rd, mem_wr, last_o;
   int          n_errors, n_compared, pts, dones;

   was_scaler i_was_scaler
   (
      .clock(clock), .rst_n(rst_n), .play_i(play_i), .play_q(play_q),
      .play_valid(play_valid), .play_ready(play_ready),
      .rt_scale_setting(scl_set), .rt_scale_header(scl_hdr),
      .rt_scale_header_valid(hdr_v), .dac_i(dac_i), .dac_q(dac_q),
      .dac_valid(dac_valid), .dac_ready(dac_ready),
      .over_range(over_range), .perm_start(perm_start),
      .perm_target_pct(pct), .seg_base(seg_base), .seg_len(seg_len),
      .perm_busy(perm_busy), .perm_done(perm_done), .mem_addr(mem_addr),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata_i(wd_i),
      .mem_wdata_q(wd_q), .mem_rdata_i(rd_i), .mem_rdata_q(rd_q)
   );
   was_mem_model i_was_mem_model
   (
      .clock(clock), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_wdata_i(wd_i), .mem_wdata_q(wd_q),
      .mem_rdata_i(rd_i), .mem_rdata_q(rd_q)
   );

   always #12.5 clock = ~clock;
   // count output points and rescale completions, keep the last point
   always @(posedge clock)
   begin
      if (dac_valid === 1'b1)
      begin
         pts <= pts + 1;
         last_i <= dac_i;
         last_q <= dac_q;
         last_o <= over_range;
      end
      if (perm_done === 1'b1)
         dones <= dones + 1;
   end

   // expected runtime product: floor of sample times q1.15 scale
   function automatic logic [15:0] scl(input logic [15:0] s, k);
      logic signed [33:0] p;
      begin
         p = $signed(s) * $signed({1'b0, k});
         return p[30:15];
      end
   endfunction
   // expected over-range: scaled value beyond plus or minus 7fff
   function automatic logic over(input logic [15:0] s, k);
      logic signed [33:0] p;
      begin
         p = ($signed(s) * $signed({1'b0, k})) >>> 15;
         return p > 34'sd32767 || p < -34'sd32767;
      end
   endfunction
   function automatic longint mag(input logic [15:0] s);
      return s[15] ? 65536 - longint'(s) : longint'(s);
   endfunction

   task automatic check(input string nm, input logic [15:0] seen, exp);
      begin
         n_compared++;
         if (seen !== exp)
         begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task automatic finish_test();
      begin
         $display("compared %0d mismatches %0d", n_compared, n_errors);
         if (n_errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   task automatic stall();
      begin
         n_errors++;
         $display("wrong value handshake expected answer seen none");
         finish_test();
      end
   endtask

   // one sample, held until the fifo takes it
   task automatic push(input logic [15:0] i, q);
      int k;
      begin
         play_i <= i;
         play_q <= q;
         play_valid <= 1'b1;
         @(negedge clock);
         for (k = 0; play_ready !== 1'b1 && k < 100; k++) @(negedge clock);
         if (k == 100) stall();
         @(posedge clock);
      end
   endtask
   // three equal samples, so the final point sits on the scaled value
   task automatic stream(input logic [15:0] i, q, s);
      int k, goal;
      begin
         goal = pts + 12;
         for (k = 0; k < 3; k++) push(i, q);
         play_valid <= 1'b0;
         for (k = 0; pts < goal && k < 100; k++) @(posedge clock);
         if (k == 100) stall();
         repeat (4) @(posedge clock);
         check("points", 16'(pts), 16'(goal));
         check("dac_i", last_i, scl(i, s));
         check("dac_q", last_q, scl(q, s));
         check("over", {15'h0, last_o}, {15'h0, over(i, s) || over(q, s)});
      end
   endtask

   task automatic t_rescale();
      begin
         scl_set <= 16'h4000;
         stream(16'h0123, 16'hfed3, 16'h4000);
         // gain of 1.5 drives i past full scale: flagged, output wraps
         scl_set <= 16'hc000;
         stream(16'h6000, 16'h0100, 16'hc000);
         scl_set <= 16'h8000;
         stream(16'h0123, 16'hfed3, 16'h8000);
         $display("test rescale done");
      end
   endtask
   task automatic t_header();
      begin
         scl_hdr <= 16'h2000;
         hdr_v <= 1'b1;
         stream(16'h7fff, 16'h8000, 16'h2000);
         hdr_v <= 1'b0;
         stream(16'h7fff, 16'h8000, 16'h8000);
         $display("test header done");
      end
   endtask
   // converter stalls until the buffer refuses, then drains
   task automatic t_fill();
      int p;
      begin
         p = pts;
         dac_ready <= 1'b0;
         play_valid <= 1'b1;
         repeat (40) @(posedge clock);
         @(negedge clock);
         check("ready full", {15'h0, play_ready}, 16'h0000);
         @(posedge clock);
         play_valid <= 1'b0;
         dac_ready <= 1'b1;
         repeat (90) @(posedge clock);
         // 16 buffered samples plus the one held, four points each
         check("fill points", 16'(pts - p), 16'h0044);
         $display("test fill done");
      end
   endtask
   // second start while busy must be ignored
   task automatic t_perm(input logic [7:0] tgt);
      longint pk, r, a;
      logic [15:0] ei [4];
      logic [15:0] eq [4];
      int k, d;
      begin
         pk = 0;
         for (k = 0; k < 4; k++)
         begin
            a = mag(i_was_mem_model.mi[k+4]);
            pk = a > pk ? a : pk;
            a = mag(i_was_mem_model.mq[k+4]);
            pk = a > pk ? a : pk;
         end
         r = longint'(tgt) * 32767 * 32768 / (100 * pk);
         for (k = 0; k < 4; k++)
         begin
            a = longint'($signed(i_was_mem_model.mi[k+4])) * r;
            ei[k] = a[30:15];
            a = longint'($signed(i_was_mem_model.mq[k+4])) * r;
            eq[k] = a[30:15];
         end
         d = dones;
         pct <= tgt;
         perm_start <= 1'b1;
         @(posedge clock);
         perm_start <= 1'b0;
         repeat (3) @(posedge clock);
         perm_start <= 1'b1;
         @(posedge clock);
         perm_start <= 1'b0;
         for (k = 0; dones == d && k < 200; k++) @(posedge clock);
         if (k == 200) stall();
         repeat (30) @(posedge clock);
         check("done count", 16'(dones - d), 16'h0001);
         for (k = 0; k < 4; k++)
         begin
            check("mem i", i_was_mem_model.mi[k+4], ei[k]);
            check("mem q", i_was_mem_model.mq[k+4], eq[k]);
         end
         $display("test perm done");
      end
   endtask

   initial
   begin
      clock = 1'b0; rst_n = 1'b0; play_valid = 1'b0; hdr_v = 1'b0;
      play_i = 16'h0100; play_q = 16'h0100; scl_set = 16'h8000;
      scl_hdr = 16'h0000; dac_ready = 1'b1; perm_start = 1'b0;
      pct = 8'h64; seg_base = 12'h004; seg_len = 12'h004;
      n_errors = 0; n_compared = 0; pts = 0; dones = 0;
      i_was_mem_model.mi[4:7] = '{16'h4000, 16'hc001, 16'h0123, 16'h0005};
      i_was_mem_model.mq[4:7] = '{16'hf000, 16'h0800, 16'h0001, 16'h3000};
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      t_rescale();
      t_header();
      t_fill();
      t_perm(8'h32);
      t_perm(8'h64);
      finish_test();
   end
endmodule
